/* File: src/tscf_pkg.sv */
// Purpose: Shared constants and types for the thermocouple status/config bank
// Assumes: 8-bit register port, temperatures are 16-bit two's complement
// Notes: Temperature LSB is 0.0625 degree
package tscf_pkg;
	localparam int unsigned REG_W = 8;
	localparam int unsigned TEMP_W = 16;
	localparam int unsigned FRAC_W = 8;
	localparam int unsigned ACC_W = TEMP_W + FRAC_W + 4;
	localparam int unsigned NUM_ALERT = 4;
	localparam logic [REG_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [REG_W-1:0] CONFIG_RESET = 8'h00;
	localparam int unsigned STAT_BURST_BIT = 7;
	localparam int unsigned STAT_UPDATE_BIT = 6;
	localparam int unsigned STAT_RANGE_BIT = 4;
	localparam int unsigned STAT_ALERT_LSB = 0;
	localparam int unsigned CFG_TYPE_LSB = 4;
	localparam int unsigned CFG_TYPE_MSB = 6;
	localparam int unsigned CFG_COEF_LSB = 0;
	localparam int unsigned CFG_COEF_MSB = 2;
	localparam logic [REG_W-1:0] CONFIG_WR_MASK = 8'h77;
	localparam logic [2:0] COEF_OFF = 3'h0;

	typedef enum logic [2:0] {
		TSCF_TC_K = 3'b000,
		TSCF_TC_J = 3'b001,
		TSCF_TC_T = 3'b010,
		TSCF_TC_N = 3'b011,
		TSCF_TC_S = 3'b100,
		TSCF_TC_E = 3'b101,
		TSCF_TC_B = 3'b110,
		TSCF_TC_R = 3'b111
	} tscf_tc_type_t;

	typedef enum logic [1:0] {
		TSCF_F_EMPTY = 2'b00,
		TSCF_F_RUN = 2'b01,
		TSCF_F_CALC = 2'b10
	} tscf_fstate_t;
endpackage

/* File: src/tscf_filt_if.sv */
// Purpose: Link between register bank and smoothing filter
// Assumes: Single clock domain
// Notes: Carries sample, coefficient, restart and result
`timescale 1ns/1ps
interface tscf_filt_if;
	logic sample_valid;
	logic signed [15:0] sample;
	logic [2:0] coef;
	logic restart;
	logic out_valid;
	logic signed [15:0] result;
	modport bank (output sample_valid, sample, coef, restart,
		input out_valid, result);
	modport filt (input sample_valid, sample, coef, restart,
		output out_valid, result);
endinterface

/* File: src/tscf_smooth.sv */
// Purpose: First-order recursive exponential smoothing of hot-junction data
// Assumes: Samples arrive no faster than one every two cycles
// Notes: k = 2/(2^n+1) applied as Y += (X-Y)*2/(2^n+1)
`timescale 1ns/1ps
module tscf_smooth (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	tscf_filt_if.filt f
);
	localparam int unsigned AW = tscf_pkg::ACC_W;
	localparam int unsigned FW = tscf_pkg::FRAC_W;

	tscf_pkg::tscf_fstate_t state_r;
	tscf_pkg::tscf_fstate_t state_nxt;
	logic signed [AW-1:0] acc_r;
	logic signed [AW-1:0] acc_nxt;
	logic signed [AW-1:0] x_ext;
	logic signed [AW-1:0] diff_r;
	logic signed [AW-1:0] diff_scaled;
	logic signed [AW-1:0] step;
	logic signed [AW-1:0] rounded;
	logic [AW-1:0] denom;
	logic valid_r;

	// Fraction bits keep resolution well below one 0.0625 degree LSB
	assign x_ext = AW'(f.sample) <<< FW;
	assign denom = (AW'(1) << f.coef) + AW'(1);
	assign diff_scaled = diff_r <<< 1;
	// Single-cycle divide: area traded for a fixed one-cycle latency
	assign step = diff_scaled / $signed(denom);
	assign rounded = acc_r + (AW'(1) <<< (FW - 1));

	always_comb begin
		state_nxt = state_r;
		acc_nxt = acc_r;
		case (state_r)
			tscf_pkg::TSCF_F_EMPTY: begin
				if (f.sample_valid) begin
					acc_nxt = x_ext;
					state_nxt = tscf_pkg::TSCF_F_RUN;
				end
			end
			tscf_pkg::TSCF_F_RUN: begin
				if (f.sample_valid) begin
					if (f.coef == tscf_pkg::COEF_OFF) begin
						acc_nxt = x_ext;
					end else begin
						state_nxt = tscf_pkg::TSCF_F_CALC;
					end
				end
			end
			tscf_pkg::TSCF_F_CALC: begin
				acc_nxt = acc_r + step;
				state_nxt = tscf_pkg::TSCF_F_RUN;
			end
			default: begin
				state_nxt = tscf_pkg::TSCF_F_EMPTY;
			end
		endcase
		if (f.restart) begin
			state_nxt = tscf_pkg::TSCF_F_EMPTY;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_r <= tscf_pkg::TSCF_F_EMPTY;
			acc_r <= '0;
			diff_r <= '0;
			valid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			diff_r <= x_ext - acc_r;
			valid_r <= (state_r != state_nxt || acc_r != acc_nxt)
				&& state_nxt == tscf_pkg::TSCF_F_RUN && !f.restart;
		end
	end

	assign f.out_valid = valid_r;
	assign f.result = rounded[FW +: tscf_pkg::TEMP_W];
endmodule

/* File: src/tscf_bank.sv */
// Purpose: Status and sensor configuration registers with hot-junction filter
// Assumes: Register port is a simple synchronous read/write strobe interface
// Notes: Conversion engine supplies raw samples, range and done events
`timescale 1ns/1ps
module tscf_bank (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_status_wr,
	input wire logic i_config_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_status,
	output logic [7:0] o_config,
	input wire logic i_conv_done,
	input wire logic i_burst_done,
	input wire logic i_burst_enabled,
	input wire logic i_input_over_range,
	input wire logic signed [15:0] i_raw_hot,
	input wire logic signed [15:0] i_delta_in,
	input wire logic signed [15:0] i_cold_junction_temp,
	input wire logic [3:0] i_alert_use_cold,
	input wire logic signed [15:0] i_alert_limit_one,
	input wire logic signed [15:0] i_alert_limit_two,
	input wire logic signed [15:0] i_alert_limit_three,
	input wire logic signed [15:0] i_alert_limit_four,
	output logic [2:0] o_coef_set_sel,
	output logic signed [15:0] o_hot_junction_temp,
	output logic signed [15:0] o_delta_temp
);
	tscf_filt_if fl ();

	logic burst_flag_r;
	logic update_flag_r;
	logic range_r;
	logic [3:0] alert_r;
	logic [2:0] type_r;
	logic [2:0] coef_r;
	logic signed [15:0] hot_r;
	logic signed [15:0] delta_r;
	logic [7:0] cfg_wr_val;
	logic burst_clr;
	logic update_clr;
	logic conv_ok;
	logic [3:0] alert_nxt;
	logic signed [15:0] limit [4];
	tscf_pkg::tscf_tc_type_t tc_type;

	////////////////////////////////////////////////////////////////////////
	// Write decode
	// Writing 0 clears the burst or update flag; writing 1 has no effect
	assign burst_clr = i_status_wr && !i_wdata[tscf_pkg::STAT_BURST_BIT];
	assign update_clr = i_status_wr && !i_wdata[tscf_pkg::STAT_UPDATE_BIT];
	assign cfg_wr_val = i_wdata & tscf_pkg::CONFIG_WR_MASK;
	// Out-of-range samples never reach the filter or the registers
	assign conv_ok = i_conv_done && !i_input_over_range;

	assign tc_type = tscf_pkg::tscf_tc_type_t'(type_r);
	// Correction table lookup is indexed by the live type field
	assign o_coef_set_sel = tc_type;

	////////////////////////////////////////////////////////////////////////
	// Filter connection
	assign fl.sample_valid = conv_ok;
	assign fl.sample = i_raw_hot;
	assign fl.coef = coef_r;
	assign fl.restart = i_config_wr;

	tscf_smooth u_smooth (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.f(fl)
	);

	////////////////////////////////////////////////////////////////////////
	// Alert comparisons
	assign limit[0] = i_alert_limit_one;
	assign limit[1] = i_alert_limit_two;
	assign limit[2] = i_alert_limit_three;
	assign limit[3] = i_alert_limit_four;

	genvar g;
	generate
		for (g = 0; g < tscf_pkg::NUM_ALERT; g++) begin : g_alert
			logic signed [15:0] src;
			assign src = i_alert_use_cold[g] ? i_cold_junction_temp : hot_r;
			assign alert_nxt[g] = src > limit[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			burst_flag_r <= tscf_pkg::STATUS_RESET[tscf_pkg::STAT_BURST_BIT];
			update_flag_r <= tscf_pkg::STATUS_RESET[tscf_pkg::STAT_UPDATE_BIT];
		end else begin
			// Set wins over a clear in the same cycle
			if (i_burst_enabled && i_burst_done) begin
				burst_flag_r <= 1'b1;
			end else if (burst_clr) begin
				burst_flag_r <= 1'b0;
			end
			if (conv_ok) begin
				update_flag_r <= 1'b1;
			end else if (update_clr) begin
				update_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			range_r <= tscf_pkg::STATUS_RESET[tscf_pkg::STAT_RANGE_BIT];
			alert_r <= tscf_pkg::STATUS_RESET[tscf_pkg::STAT_ALERT_LSB +:
				tscf_pkg::NUM_ALERT];
		end else begin
			range_r <= i_input_over_range;
			alert_r <= alert_nxt;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			type_r <= tscf_pkg::CONFIG_RESET[tscf_pkg::CFG_TYPE_MSB:
				tscf_pkg::CFG_TYPE_LSB];
			coef_r <= tscf_pkg::CONFIG_RESET[tscf_pkg::CFG_COEF_MSB:
				tscf_pkg::CFG_COEF_LSB];
		end else if (i_config_wr) begin
			type_r <= cfg_wr_val[tscf_pkg::CFG_TYPE_MSB:
				tscf_pkg::CFG_TYPE_LSB];
			coef_r <= cfg_wr_val[tscf_pkg::CFG_COEF_MSB:
				tscf_pkg::CFG_COEF_LSB];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			hot_r <= '0;
			delta_r <= '0;
		end else begin
			if (fl.out_valid) begin
				hot_r <= fl.result;
			end
			if (conv_ok) begin
				delta_r <= i_delta_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read views; unimplemented bits read zero
	always_comb begin
		o_status = '0;
		o_status[tscf_pkg::STAT_BURST_BIT] = burst_flag_r;
		o_status[tscf_pkg::STAT_UPDATE_BIT] = update_flag_r;
		o_status[tscf_pkg::STAT_RANGE_BIT] = range_r;
		o_status[tscf_pkg::STAT_ALERT_LSB +: tscf_pkg::NUM_ALERT] = alert_r;
		o_config = '0;
		o_config[tscf_pkg::CFG_TYPE_MSB:tscf_pkg::CFG_TYPE_LSB] = type_r;
		o_config[tscf_pkg::CFG_COEF_MSB:tscf_pkg::CFG_COEF_LSB] = coef_r;
	end

	assign o_hot_junction_temp = hot_r;
	assign o_delta_temp = delta_r;
endmodule

/* File: test/tscf_bank_monitor.sv */
// Purpose: Port-level checks for the status/config bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bench keeps samples at least three cycles apart
`timescale 1ns/1ps
module tscf_bank_monitor (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_status_wr,
	input wire logic i_config_wr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_status,
	input wire logic [7:0] o_config,
	input wire logic i_conv_done,
	input wire logic i_burst_done,
	input wire logic i_burst_enabled,
	input wire logic i_input_over_range,
	input wire logic signed [15:0] i_raw_hot,
	input wire logic [2:0] o_coef_set_sel,
	input wire logic signed [15:0] o_hot_junction_temp,
	input wire logic [3:0] i_alert_use_cold,
	input wire logic signed [15:0] i_cold_junction_temp,
	input wire logic signed [15:0] i_alert_limit_four
);
	wire ok_in = !i_input_over_range && !i_config_wr;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	////////////////////////////////////////////////////////////////////
	chk_cfg_store: assert property (
		i_config_wr |=> o_config == ($past(i_wdata) & 8'h77)
	) else $error("config readback wrong");
	chk_type_sel: assert property (
		o_coef_set_sel == o_config[6:4]
	) else $error("coefficient set select wrong");
	chk_update_set: assert property (
		i_conv_done && ok_in |=> o_status[6]
	) else $error("update flag not set");
	chk_update_clear: assert property (
		i_status_wr && !i_wdata[6] && !i_conv_done |=> !o_status[6]
	) else $error("update flag not cleared");
	chk_range_skip: assert property (
		i_conv_done && i_input_over_range |=>
		$stable(o_hot_junction_temp)[*3]
	) else $error("hot register moved out of range");
	chk_burst_set: assert property (
		i_burst_done && i_burst_enabled |=> o_status[7]
	) else $error("burst flag not set");
	chk_burst_idle: assert property (
		!i_burst_enabled && !o_status[7] |=> !o_status[7]
	) else $error("burst flag set while disabled");
	chk_range_flag: assert property (
		!$past(i_reset) |-> o_status[4] == $past(i_input_over_range)
	) else $error("range flag wrong");
	chk_direct_load: assert property (
		o_config[2:0] == 3'h0 && i_conv_done && ok_in |->
		##2 o_hot_junction_temp == $past(i_raw_hot, 2)
	) else $error("unfiltered sample not passed");
	chk_alert_cold: assert property (
		!$past(i_reset) && $past(i_alert_use_cold[3]) |->
		o_status[3] ==
		($past(i_cold_junction_temp) > $past(i_alert_limit_four))
	) else $error("cold alert status wrong");
	cover property (i_conv_done && o_config[2:0] != 3'h0);
	cover property (i_burst_done && i_burst_enabled);
	cover property (i_conv_done && i_input_over_range);
endmodule
bind tscf_bank tscf_bank_monitor tscf_bank_monitor_inst (
	.i_sys_clk(i_sys_clk),
	.i_reset(i_reset),
	.i_status_wr(i_status_wr),
	.i_config_wr(i_config_wr),
	.i_wdata(i_wdata),
	.o_status(o_status),
	.o_config(o_config),
	.i_conv_done(i_conv_done),
	.i_burst_done(i_burst_done),
	.i_burst_enabled(i_burst_enabled),
	.i_input_over_range(i_input_over_range),
	.i_raw_hot(i_raw_hot),
	.o_coef_set_sel(o_coef_set_sel),
	.o_hot_junction_temp(o_hot_junction_temp),
	.i_alert_use_cold(i_alert_use_cold),
	.i_cold_junction_temp(i_cold_junction_temp),
	.i_alert_limit_four(i_alert_limit_four)
);

/* File: test/tscf_engine_model.sv */
// Purpose: Conversion engine model feeding samples and events
// Assumes: Driven on the falling edge
// Notes: Sample lines scramble once the pulse ends
`timescale 1ns/1ps
module tscf_engine_model (
	input wire logic i_sys_clk,
	output logic o_conv_done,
	output logic o_burst_done,
	output logic signed [15:0] o_raw_hot,
	output logic signed [15:0] o_delta_in
);
	initial begin
		o_conv_done = 1'h0;
		o_burst_done = 1'h0;
		o_raw_hot = 16'h0000;
		o_delta_in = 16'h0000;
	end
	task automatic send(input logic [15:0] h, input logic [15:0] d);
		@(negedge i_sys_clk);
		o_raw_hot <= h;
		o_delta_in <= d;
		o_conv_done <= 1'h1;
		@(negedge i_sys_clk);
		o_conv_done <= 1'h0;
		// Stale data is not held, so a late read shows garbage
		o_raw_hot <= ~h;
		o_delta_in <= ~d;
		repeat (3) @(negedge i_sys_clk);
	endtask
	task automatic burst();
		@(negedge i_sys_clk);
		o_burst_done <= 1'h1;
		@(negedge i_sys_clk);
		o_burst_done <= 1'h0;
	endtask
endmodule

/* File: test/tscf_bank_tb.sv */
// Purpose: Self-checking bench for the status/config bank
// Assumes: Engine model supplies samples and burst events
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module tscf_bank_tb;
	logic i_sys_clk = 1'h0, i_reset = 1'h1;
	logic i_status_wr = 1'h0, i_config_wr = 1'h0;
	logic i_burst_enabled = 1'h0, i_input_over_range = 1'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [3:0] i_alert_use_cold = 4'h8;
	logic signed [15:0] i_cold_junction_temp = 16'h0010;
	logic signed [15:0] i_alert_limit_one = 16'h0100;
	logic signed [15:0] i_alert_limit_two = 16'h0123;
	logic signed [15:0] i_alert_limit_three = 16'h7fff;
	logic signed [15:0] i_alert_limit_four = 16'h000f;
	logic i_conv_done, i_burst_done;
	logic signed [15:0] i_raw_hot, i_delta_in;
	logic signed [15:0] o_hot_junction_temp, o_delta_temp;
	logic [7:0] o_status, o_config;
	logic [2:0] o_coef_set_sel;
	int err_total = 0, samples_checked = 0, cyc = 0;
	tscf_bank tscf_bank_inst (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_status_wr(i_status_wr),
		.i_config_wr(i_config_wr),
		.i_wdata(i_wdata),
		.o_status(o_status),
		.o_config(o_config),
		.i_conv_done(i_conv_done),
		.i_burst_done(i_burst_done),
		.i_burst_enabled(i_burst_enabled),
		.i_input_over_range(i_input_over_range),
		.i_raw_hot(i_raw_hot),
		.i_delta_in(i_delta_in),
		.i_cold_junction_temp(i_cold_junction_temp),
		.i_alert_use_cold(i_alert_use_cold),
		.i_alert_limit_one(i_alert_limit_one),
		.i_alert_limit_two(i_alert_limit_two),
		.i_alert_limit_three(i_alert_limit_three),
		.i_alert_limit_four(i_alert_limit_four),
		.o_coef_set_sel(o_coef_set_sel),
		.o_hot_junction_temp(o_hot_junction_temp),
		.o_delta_temp(o_delta_temp)
	);
	tscf_engine_model tscf_engine_model_inst (
		.i_sys_clk(i_sys_clk),
		.o_conv_done(i_conv_done),
		.o_burst_done(i_burst_done),
		.o_raw_hot(i_raw_hot),
		.o_delta_in(i_delta_in)
	);
	initial forever #5 i_sys_clk = ~i_sys_clk;
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic cfg, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_config_wr <= cfg;
		i_status_wr <= !cfg;
		i_wdata <= d;
		@(negedge i_sys_clk);
		i_config_wr <= 1'h0;
		i_status_wr <= 1'h0;
		i_wdata <= ~d;
	endtask
	task automatic conclude();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Whole run is about 90 cycles
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge i_sys_clk);
		chk(o_status, 8'h00);
		chk(o_config, 8'h00);
		i_reset <= 1'h0;
		wr(1'h1, 8'hff);
		chk(o_config, 8'h77);
		for (int t = 0; t < 8; t++) begin
			wr(1'h1, 8'(t << 4));
			chk(o_coef_set_sel, 16'(t));
		end
		tscf_engine_model_inst.send(16'h0123, 16'h0045);
		chk(o_hot_junction_temp, 16'h0123);
		chk(o_delta_temp, 16'h0045);
		// Alert 2 sits exactly on its limit and must stay clear
		chk(o_status, 8'h49);
		wr(1'h0, 8'hbf);
		chk(o_status, 8'h09);
		tscf_engine_model_inst.burst();
		chk(o_status[7], 1'h0);
		i_burst_enabled <= 1'h1;
		tscf_engine_model_inst.burst();
		chk(o_status[7], 1'h1);
		wr(1'h0, 8'h7f);
		chk(o_status, 8'h09);
		i_input_over_range <= 1'h1;
		tscf_engine_model_inst.send(16'h0200, 16'h0011);
		chk(o_status, 8'h19);
		chk(o_hot_junction_temp, 16'h0123);
		chk(o_delta_temp, 16'h0045);
		i_input_over_range <= 1'h0;
		wr(1'h1, 8'h01);
		tscf_engine_model_inst.send(16'h0100, 16'h0000);
		chk(o_hot_junction_temp, 16'h0100);
		tscf_engine_model_inst.send(16'h0400, 16'h0000);
		chk(o_hot_junction_temp, 16'h0300);
		// Without a restart the next output would blend with 0x0300
		wr(1'h1, 8'h02);
		tscf_engine_model_inst.send(16'h0500, 16'h0000);
		chk(o_hot_junction_temp, 16'h0500);
		tscf_engine_model_inst.send(16'h0000, 16'h0000);
		chk(o_hot_junction_temp, 16'h0300);
		// Mid-run reset must clear every register and the filter state
		i_reset <= 1'h1;
		repeat (2) @(negedge i_sys_clk);
		chk(o_status, 8'h00);
		chk(o_config, 8'h00);
		chk(o_hot_junction_temp, 16'h0000);
		chk(o_delta_temp, 16'h0000);
		i_reset <= 1'h0;
		tscf_engine_model_inst.send(16'h0040, 16'h0007);
		chk(o_hot_junction_temp, 16'h0040);
		chk(o_delta_temp, 16'h0007);
		chk(o_status, 8'h48);
		conclude();
	end
endmodule
